// [rtl/info_word_packetizer.sv]
// Frame-information word packetizer: filters, formats, queues and
// shifts 32-bit packets to the host over a host-clocked serial link.
// Assumes words arrive on sys_clk; link pins are asynchronous.
//
// Operation
// - First word of each phase dropped, unless manual collapse mode.
// - Time flag forwards date, time and system words 2 to 4.
// - All-words flag forwards every word 2 to 4.
// - With either flag, errored words 2 to 4 always forwarded, flagged.
// - Clean system-message words 2 to 4 mark following vectors and messages undecoded.
// - Packet identifier byte is all zero.
// - Byte 2 holds error, phase, format; 14 payload bits below.
// - Error flag: more than two bit errors or check failure.
// - Phase a to d encoded 0 to 3.
// - Unused bits driven zero; host ignores them.
// - Local id, reserved, country words need the all-words flag.
// - Date, time, system words need either flag.
// - Packets shifted out most significant bit first.
// - 32-packet queue; overflow halts decoding and clears it.
`timescale 1ns/1ps
module info_word_packetizer #(
    parameter int QUEUE_DEPTH = info_pkt_pkg::QUEUE_DEPTH_DEF,
    parameter logic [31:0] IDLE_WORD = info_pkt_pkg::IDLE_WORD_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [2:0] word_number,
    input wire logic [1:0] word_phase,
    input wire logic [2:0] word_format,
    input wire logic [13:0] word_payload,
    input wire logic [2:0] word_bit_errors,
    input wire logic word_check_fail,
    input wire logic send_time_words_flag,
    input wire logic send_all_info_words_flag,
    input wire logic manual_collapse_mode,
    input wire logic decode_restart,
    output logic decode_halted,
    output logic vector_msg_skip,
    output logic packet_pending,
    input wire logic link_sclk,
    input wire logic link_sel_n,
    output logic link_miso_out,
    output logic link_miso_oe
);
    localparam int AW = $clog2(QUEUE_DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(QUEUE_DEPTH);

    generate
        if (QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("QUEUE_DEPTH must be a power of two >= 2");
        end
    endgenerate

    // ==========================================================
    // Classification and packing
    function automatic logic in_range(input logic [2:0] num);
        return num >= info_pkt_pkg::LOW_FWD_WORD &&
               num <= info_pkt_pkg::HIGH_FWD_WORD;
    endfunction

    function automatic logic want_word(input logic [2:0] num,
                                       input logic [2:0] fmt,
                                       input logic err,
                                       input logic time_f,
                                       input logic all_f,
                                       input logic collapse);
        logic w;
        w = 1'b0;
        if (num == info_pkt_pkg::FIRST_WORD)
            w = collapse;
        else if (!in_range(num))
            w = 1'b0;
        else if (err)
            w = time_f || all_f;
        else
            case (fmt)
                info_pkt_pkg::FMT_DATE,
                info_pkt_pkg::FMT_TIME,
                info_pkt_pkg::FMT_SYS_MSG: w = time_f || all_f;
                default: w = all_f;
            endcase
        return w;
    endfunction

    function automatic logic [31:0] pack(input logic err,
                                         input logic [1:0] phase,
                                         input logic [2:0] fmt,
                                         input logic [13:0] payload);
        logic [31:0] p;
        p = '0;
        p[info_pkt_pkg::ID_HI:info_pkt_pkg::ID_LO] =
            info_pkt_pkg::INFO_PKT_ID;
        p[info_pkt_pkg::ERR_BIT] = err;
        p[info_pkt_pkg::PHASE_HI:info_pkt_pkg::PHASE_LO] = phase;
        p[info_pkt_pkg::FMT_HI:info_pkt_pkg::FMT_LO] = fmt;
        p[info_pkt_pkg::PAYLOAD_HI:info_pkt_pkg::PAYLOAD_LO] = payload;
        return p;
    endfunction

    // ==========================================================
    // Input stage
    logic acc, word_err, word_want;
    logic ready_q, ready_d, pkt_valid_q, pkt_valid_d, skip_q, skip_d;
    logic [31:0] pkt_q, pkt_d;
    logic halted_q, halted_d;
    pkt_if in_if ();
    pkt_if out_if ();

    assign acc = word_valid && ready_q;
    assign word_err = (word_bit_errors > info_pkt_pkg::BIT_ERR_LIMIT) ||
                      word_check_fail;
    assign word_want = want_word(word_number, word_format, word_err,
                                 send_time_words_flag,
                                 send_all_info_words_flag,
                                 manual_collapse_mode);
    assign in_if.valid = pkt_valid_q;
    assign in_if.data = pkt_q;

    always_comb
    begin
        pkt_d = pkt_q;
        pkt_valid_d = pkt_valid_q;
        skip_d = skip_q;
        if (in_if.valid && in_if.ready)
            pkt_valid_d = 1'b0;
        if (acc)
        begin
            // New phase starts a new frame
            if (word_number == info_pkt_pkg::FIRST_WORD)
                skip_d = 1'b0;
            if (in_range(word_number) && !word_err &&
                word_format == info_pkt_pkg::FMT_SYS_MSG)
                skip_d = 1'b1;
            if (word_want)
            begin
                pkt_d = pack(word_err, word_phase, word_format, word_payload);
                pkt_valid_d = 1'b1;
            end
        end
        ready_d = !pkt_valid_d && !halted_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ready_q <= 1'b0;
            pkt_valid_q <= 1'b0;
            pkt_q <= '0;
            skip_q <= 1'b0;
        end
        else
        begin
            ready_q <= ready_d;
            pkt_valid_q <= pkt_valid_d;
            pkt_q <= pkt_d;
            skip_q <= skip_d;
        end
    end

    pkt_skid_buf #(
        .ENTRIES(info_pkt_pkg::BUF_ENTRIES)
    ) u_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .up(in_if.snk),
        .dn(out_if.src)
    );

    // ==========================================================
    // Transmit queue
    // Full queue refuses the buffer's word; without a pop, overflow clears it that cycle
    logic [31:0] qmem [QUEUE_DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop, overflow, pending_d;

    assign out_if.ready = (cnt_q != FULL_CNT);
    assign push = out_if.valid && out_if.ready;
    assign overflow = out_if.valid && !out_if.ready && !pop;

    always_comb
    begin
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        halted_d = halted_q;
        if (decode_restart)
            halted_d = 1'b0;
        if (overflow)
        begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
            halted_d = 1'b1;
        end
        pending_d = (cnt_d != '0);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            halted_q <= 1'b0;
            packet_pending <= 1'b0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            halted_q <= halted_d;
            packet_pending <= pending_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            qmem[wr_q] <= out_if.data;
        end
    end

    // ==========================================================
    // Serial link, sampled on sys_clk
    // Packet leaves the queue at select; an aborted read loses it
    logic sclk_meta_q, sclk_sync_q, sclk_prev_q;
    logic sel_meta_q, sel_sync_n_q;
    logic sclk_rise, sclk_fall;
    info_pkt_pkg::link_state_t state_q, state_d;
    logic [31:0] shift_q, shift_d;
    logic [5:0] bits_q, bits_d;
    logic oe_d;

    assign sclk_rise = sclk_sync_q && !sclk_prev_q;
    assign sclk_fall = !sclk_sync_q && sclk_prev_q;
    assign link_miso_out = shift_q[31];

    always_comb
    begin
        state_d = state_q;
        shift_d = shift_q;
        bits_d = bits_q;
        pop = 1'b0;
        case (state_q)
            info_pkt_pkg::LINK_IDLE:
                if (!sel_sync_n_q)
                begin
                    pop = (cnt_q != '0);
                    shift_d = pop ? qmem[rd_q] : IDLE_WORD;
                    bits_d = '0;
                    state_d = info_pkt_pkg::LINK_SHIFT;
                end
            info_pkt_pkg::LINK_SHIFT:
                if (sel_sync_n_q)
                    state_d = info_pkt_pkg::LINK_IDLE;
                else
                begin
                    if (sclk_rise && bits_q != info_pkt_pkg::PKT_BITS)
                        bits_d = bits_q + 6'h01;
                    if (sclk_fall && bits_q != '0)
                        shift_d = {shift_q[30:0], 1'b0};
                end
            default: state_d = info_pkt_pkg::LINK_IDLE;
        endcase
        oe_d = !sel_sync_n_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sclk_meta_q <= 1'b0;
            sclk_sync_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            sel_meta_q <= 1'b1;
            sel_sync_n_q <= 1'b1;
            state_q <= info_pkt_pkg::LINK_IDLE;
            shift_q <= '0;
            bits_q <= '0;
            link_miso_oe <= 1'b0;
        end
        else
        begin
            sclk_meta_q <= link_sclk;
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
            sel_meta_q <= link_sel_n;
            sel_sync_n_q <= sel_meta_q;
            state_q <= state_d;
            shift_q <= shift_d;
            bits_q <= bits_d;
            link_miso_oe <= oe_d;
        end
    end

    assign word_ready = ready_q;
    assign decode_halted = halted_q;
    assign vector_msg_skip = skip_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_FIRST_DROP: assert property (
        acc && word_number == info_pkt_pkg::FIRST_WORD &&
        !manual_collapse_mode |=> !pkt_valid_q)
        else $error("first word forwarded outside collapse mode");
    AST_TIME_FWD: assert property (
        acc && send_time_words_flag && in_range(word_number) &&
        word_format == info_pkt_pkg::FMT_TIME |=> pkt_valid_q)
        else $error("time word not forwarded");
    AST_ALL_FWD: assert property (
        acc && send_all_info_words_flag && in_range(word_number)
        |=> pkt_valid_q)
        else $error("word not forwarded with all-words flag");
    AST_ERR_FWD: assert property (
        acc && word_err && in_range(word_number) &&
        (send_time_words_flag || send_all_info_words_flag)
        |=> pkt_valid_q && pkt_q[info_pkt_pkg::ERR_BIT])
        else $error("errored word not forwarded flagged");
    AST_SYS_SKIP: assert property (
        acc && in_range(word_number) && !word_err &&
        word_format == info_pkt_pkg::FMT_SYS_MSG |=> vector_msg_skip)
        else $error("system message did not suppress vectors");
    AST_ID_ZERO: assert property (
        state_q == info_pkt_pkg::LINK_IDLE && !sel_sync_n_q &&
        cnt_q != '0 |=>
        shift_q[info_pkt_pkg::ID_HI:info_pkt_pkg::ID_LO] ==
        info_pkt_pkg::INFO_PKT_ID)
        else $error("packet identifier not zero");
    AST_LAYOUT: assert property (
        acc && word_want |=>
        pkt_q[22:21] == $past(word_phase) &&
        pkt_q[18:16] == $past(word_format) &&
        pkt_q[13:0] == $past(word_payload))
        else $error("packet fields misplaced");
    AST_ERR_FLAG: assert property (
        acc && word_want |=> pkt_q[23] == $past(word_err))
        else $error("error flag wrong");
    AST_RSV_GATED: assert property (
        acc && !send_all_info_words_flag && !word_err &&
        in_range(word_number) &&
        word_format == info_pkt_pkg::FMT_RSV3 |=> !pkt_valid_q)
        else $error("reserved word forwarded without all-words flag");
    AST_MSB_FIRST: assert property (
        state_q == info_pkt_pkg::LINK_SHIFT && !sel_sync_n_q &&
        sclk_fall && bits_q != '0 |=> link_miso_out == $past(shift_q[30]))
        else $error("shift order wrong");
    AST_OVERFLOW: assert property (
        overflow |=> decode_halted && cnt_q == '0 ##1 !word_ready)
        else $error("overflow did not halt and clear");

    COV_ERR_WORD: cover property (acc && word_want && word_err);
    COV_OVERFLOW: cover property (overflow);
    COV_FULL_PKT: cover property (bits_q == info_pkt_pkg::PKT_BITS);

endmodule // info_word_packetizer

// [shared/info_pkt_pkg.sv]
// Constants, field layout and types of the information-word packetizer.
// Assumes nothing beyond a SystemVerilog compiler.
package info_pkt_pkg;

    // ==========================================================
    // Packet layout
    localparam int PKT_W = 32;
    localparam int PAYLOAD_W = 14;
    localparam int ID_HI = 31;
    localparam int ID_LO = 24;
    localparam int ERR_BIT = 23;
    localparam int PHASE_HI = 22;
    localparam int PHASE_LO = 21;
    localparam int FMT_HI = 18;
    localparam int FMT_LO = 16;
    localparam int PAYLOAD_HI = 13;
    localparam int PAYLOAD_LO = 0;
    localparam logic [7:0] INFO_PKT_ID = 8'h00;

    // ==========================================================
    // Word classification
    localparam logic [2:0] BIT_ERR_LIMIT = 3'h2;
    localparam logic [2:0] FIRST_WORD = 3'h1;
    localparam logic [2:0] LOW_FWD_WORD = 3'h2;
    localparam logic [2:0] HIGH_FWD_WORD = 3'h4;
    localparam logic [2:0] FMT_LOCAL_ID = 3'h0;
    localparam logic [2:0] FMT_DATE = 3'h1;
    localparam logic [2:0] FMT_TIME = 3'h2;
    localparam logic [2:0] FMT_RSV3 = 3'h3;
    localparam logic [2:0] FMT_SYS_MSG = 3'h5;

    // ==========================================================
    // Depths and link
    localparam int QUEUE_DEPTH_DEF = 32;
    localparam int BUF_ENTRIES = 2;
    localparam int BIT_CNT_W = 6;
    localparam logic [5:0] PKT_BITS = 6'h20;
    localparam logic [31:0] IDLE_WORD_DEF = 32'hffff_ffff;

    typedef enum {LINK_IDLE, LINK_SHIFT} link_state_t;

endpackage

// [shared/pkt_if.sv]
// Valid/ready packet carrier between the packetizer and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface pkt_if;
    logic valid;
    logic ready;
    logic [info_pkt_pkg::PKT_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // pkt_if

// [rtl/pkt_skid_buf.sv]
// Small valid/ready packet buffer, power-of-two entries.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module pkt_skid_buf #(
    parameter int ENTRIES = info_pkt_pkg::BUF_ENTRIES
) (
    input wire logic sys_clk,
    input wire logic reset,
    pkt_if.snk up,
    pkt_if.src dn
);
    localparam int AW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(ENTRIES);

    generate
        if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0)
        begin : g_bad_entries
            $error("pkt_skid_buf: ENTRIES must be a power of two >= 2");
        end
    endgenerate

    logic [info_pkt_pkg::PKT_W-1:0] mem [ENTRIES];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // ==========================================================
    // Handshakes
    assign up.ready = (cnt_q != FULL_CNT);
    assign dn.valid = (cnt_q != '0);
    assign dn.data = mem[rd_q];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;

    always_comb
    begin
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_q] <= up.data;
        end
    end

endmodule // pkt_skid_buf

// [sim/host_link_model.sv]
// Host end of the packet link: selects, clocks and samples one packet.
// Assumes the bench calls read_pkt; 80 ns link clock, mode 0.
`timescale 1ns/1ps
module host_link_model (
    input wire logic sys_clk,
    output logic link_sclk,
    output logic link_sel_n,
    input wire logic link_miso_out
);
    // ==========================================================
    // Idle: clock stands low, select released
    initial
    begin
        link_sclk = 1'b0;
        link_sel_n = 1'b1;
    end

    // ==========================================================
    // One packet per select; all edges fall on falling sys_clk,
    // so the device's synchronisers never race the model
    task automatic read_pkt(output logic [31:0] w);
        @(negedge sys_clk);
        link_sel_n = 1'b0;
        #80;
        for (int i = 31; i >= 0; i--)
        begin
            link_sclk = 1'b1;
            w[i] = link_miso_out;
            #40;
            link_sclk = 1'b0;
            #40;
        end
        // Fields are read by format later; unused bits ignored
        link_sel_n = 1'b1;
        #80;
    endtask
endmodule // host_link_model

// [sim/frame_info_word_packetizer_tb.sv]
// Self-checking bench of the information-word packetizer.
// Assumes the host model above; queue shrunk to 4 packets.
`timescale 1ns/1ps
module frame_info_word_packetizer_tb;
    localparam int QD = 4;
    localparam logic [31:0] IDLE = 32'ha5c3_0f96;
    // Unused packet bits masked out before comparing
    localparam logic [31:0] MASK = 32'hffe7_3fff;
    logic sys_clk, reset, word_valid, word_ready, word_check_fail;
    logic [2:0] word_number, word_format, word_bit_errors;
    logic [1:0] word_phase;
    logic [13:0] word_payload;
    logic send_time_words_flag, send_all_info_words_flag;
    logic manual_collapse_mode, decode_restart, decode_halted;
    logic vector_msg_skip, packet_pending;
    logic link_sclk, link_sel_n, link_miso_out, link_miso_oe;
    logic tf, af, col;
    logic [15:0] seed;
    logic [31:0] w;
    logic [31:0] expq[$];
    int n_errors, total_checks;

    info_word_packetizer #(.QUEUE_DEPTH(QD), .IDLE_WORD(IDLE)) DUT (
        .sys_clk, .reset, .word_valid, .word_ready, .word_number,
        .word_phase, .word_format, .word_payload, .word_bit_errors,
        .word_check_fail, .send_time_words_flag,
        .send_all_info_words_flag, .manual_collapse_mode,
        .decode_restart, .decode_halted, .vector_msg_skip,
        .packet_pending, .link_sclk, .link_sel_n, .link_miso_out,
        .link_miso_oe);
    host_link_model host (.sys_clk, .link_sclk, .link_sel_n,
        .link_miso_out);

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic fwd(logic [2:0] n, logic [2:0] f, logic e);
        if (n == 3'h1)
            return col;
        if (n < 3'h2 || n > 3'h4)
            return 1'b0;
        if (e || f == 3'h1 || f == 3'h2 || f == 3'h5)
            return tf | af;
        return af;
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        total_checks++;
        if (got !== ex)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic send(logic [2:0] n, logic [2:0] f, logic [1:0] ph,
                        logic [13:0] pl, logic [2:0] be, logic cf);
        logic e;
        int k;
        e = (be > 3'h2) || cf;
        @(negedge sys_clk);
        {word_number, word_format, word_phase} = {n, f, ph};
        {word_payload, word_bit_errors, word_check_fail} = {pl, be, cf};
        {send_time_words_flag, send_all_info_words_flag} = {tf, af};
        manual_collapse_mode = col;
        word_valid = 1'b1;
        for (k = 0; k < 200 && word_ready !== 1'b1; k++)
            @(negedge sys_clk);
        if (k == 200)
        begin
            n_errors++;
            $display("unexpected word_ready expected 1 seen %b", word_ready);
            end_of_test();
        end
        @(posedge sys_clk);
        if (fwd(n, f, e))
            expq.push_back({8'h00, e, ph, 2'h0, f, 2'h0, pl});
        @(negedge sys_clk);
        word_valid = 1'b0;
    endtask

    task automatic drain();
        logic [31:0] x;
        repeat (6) @(negedge sys_clk);
        chk("packet_pending", 32'(expq.size() != 0), 32'(packet_pending));
        for (int k = 0; k < 8 && packet_pending === 1'b1; k++)
        begin
            host.read_pkt(w);
            x = (expq.size() != 0) ? expq.pop_front() : 32'h0;
            chk("packet", x & MASK, w & MASK);
        end
        chk("leftover", 32'h0, 32'(expq.size()));
    endtask

    // ==========================================================
    // Clock and sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        {word_valid, word_number, word_format, word_phase} = '0;
        {word_payload, word_bit_errors, word_check_fail} = '0;
        {send_time_words_flag, send_all_info_words_flag} = 2'h0;
        {manual_collapse_mode, decode_restart} = 2'h0;
        {tf, af, col} = 3'h0;
        seed = 16'h465d;
        n_errors = 0;
        total_checks = 0;
        reset = 1'b1;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        chk("link_miso_oe", 32'h0, 32'(link_miso_oe));
        fork
            host.read_pkt(w);
            begin
                repeat (10) @(negedge sys_clk);
                chk("link_miso_oe", 32'h1, 32'(link_miso_oe));
            end
        join
        chk("idle_word", IDLE, w);
        chk("link_miso_oe", 32'h0, 32'(link_miso_oe));
        // Every format under every flag pairing, clean and errored
        for (int i = 0; i < 64; i++)
        begin
            seed = lfsr(seed);
            {tf, af} = {i[3], i[4]};
            send(3'(2 + seed % 3), i[2:0], seed[5:4], seed[13:0],
                 i[5] ? (seed[8] ? 3'(3 + seed[1:0]) : 3'h2)
                      : 3'(seed[1:0] % 3), i[5] & ~seed[8]);
            drain();
        end
        // First word and out-of-range numbers, collapse on and off
        for (int j = 0; j < 4; j++)
        begin
            {tf, af, col} = {2'h3, j[0]};
            send(j[1] ? 3'h1 : 3'h6, 3'h5, 2'h3, 14'h2a55, 3'h0, 1'b0);
            drain();
        end
        // Clean system-message word, then a new phase start
        {tf, af, col} = 3'h4;
        send(3'h3, 3'h5, 2'h1, 14'h1234, 3'h0, 1'b0);
        repeat (4) @(negedge sys_clk);
        chk("vector_msg_skip", 32'h1, 32'(vector_msg_skip));
        drain();
        send(3'h1, 3'h0, 2'h2, 14'h0001, 3'h0, 1'b0);
        repeat (4) @(negedge sys_clk);
        chk("vector_msg_skip", 32'h0, 32'(vector_msg_skip));
        drain();
        // Overflow: full queue plus one more, nobody reading
        for (int k = 0; k <= QD; k++)
            send(3'h2, 3'h2, 2'h0, 14'(k), 3'h0, 1'b0);
        repeat (8) @(negedge sys_clk);
        chk("decode_halted", 32'h1, 32'(decode_halted));
        chk("word_ready", 32'h0, 32'(word_ready));
        decode_restart = 1'b1;
        @(negedge sys_clk);
        decode_restart = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("decode_halted", 32'h0, 32'(decode_halted));
        chk("word_ready", 32'h1, 32'(word_ready));
        // Only the word waiting in the buffer survives the clear
        chk("packet_pending", 32'h1, 32'(packet_pending));
        host.read_pkt(w);
        chk("kept_packet", expq[QD] & MASK, w & MASK);
        for (int k = 0; k < 8 && packet_pending === 1'b1; k++)
            host.read_pkt(w);
        expq.delete();
        chk("packet_pending", 32'h0, 32'(packet_pending));
        end_of_test();
    end
endmodule // frame_info_word_packetizer_tb
